// [design/fpc_host.sv]
// Host sequencer for flash block-protection command sets
//
// Decided for this implementation: the register offsets and the strobed register port.
`default_nettype none
module fpc_host (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Software port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Flash pins
  output logic [fpc_pkg::AW-1:0] fl_addr_out,
  input wire logic [fpc_pkg::DW-1:0] fl_dq_in,
  output logic [fpc_pkg::DW-1:0] fl_dq_out,
  output logic fl_dq_oe_out,
  output logic fl_ce_n_out,
  output logic fl_oe_n_out,
  output logic fl_we_n_out,
  output logic fl_byte_n_out
);
  function automatic fpc_pkg::fpc_step_t fpc_step(input fpc_pkg::fpc_op_t op,
      input logic [3:0] i, input logic bm, input logic [fpc_pkg::AW-1:0] a,
      input logic [15:0] d, input logic [63:0] pw, input logic [7:0] code);
    fpc_pkg::fpc_step_t s;
    logic [3:0] k;
    logic [3:0] n;
    s = '0;
    k = i - fpc_pkg::PW_OFS;
    n = bm ? fpc_pkg::PW_N_B : fpc_pkg::PW_N_W;
    case (op)
      fpc_pkg::OP_ENTER, fpc_pkg::OP_EXTPROG, fpc_pkg::OP_EXTEXIT: begin
        case (i)
          4'h0: begin
            s.addr = bm ? fpc_pkg::UA1_B : fpc_pkg::UA1_W;
            s.data = {8'h00, fpc_pkg::D_AA};
          end
          4'h1: begin
            s.addr = bm ? fpc_pkg::UA2_B : fpc_pkg::UA2_W;
            s.data = {8'h00, fpc_pkg::D_55};
          end
          4'h2: begin
            s.addr = bm ? fpc_pkg::UA1_B : fpc_pkg::UA1_W;
            s.last = (op == fpc_pkg::OP_ENTER);
            if (op == fpc_pkg::OP_ENTER) begin
              s.data = {8'h00, code};
            end else if (op == fpc_pkg::OP_EXTPROG) begin
              s.data = {8'h00, fpc_pkg::D_PRG};
            end else begin
              s.addr = fpc_pkg::XIT_A;
              s.data = {8'h00, fpc_pkg::D_EXIT};
            end
          end
          default: begin
            s.last = 1'b1;
            if (op == fpc_pkg::OP_EXTPROG) begin
              s.addr = a;
              s.data = d;
            end else begin
              s.data = {8'h00, fpc_pkg::D_ZERO};
            end
          end
        endcase
      end
      fpc_pkg::OP_EXIT: begin
        s.data = {8'h00, (i == 4'h0) ? fpc_pkg::D_EXIT : fpc_pkg::D_ZERO};
        s.last = (i != 4'h0);
      end
      fpc_pkg::OP_PROG: begin
        // Serves protection bits, lock bit and one password portion
        s.data = (i == 4'h0) ? {8'h00, fpc_pkg::D_PRG} : d;
        s.addr = (i == 4'h0) ? '0 : a;
        s.last = (i != 4'h0);
      end
      fpc_pkg::OP_READ: begin
        s.rd = 1'b1;
        s.addr = a;
        s.last = 1'b1;
      end
      fpc_pkg::OP_CLRALL: begin
        s.data = {8'h00, (i == 4'h0) ? fpc_pkg::D_CLR1 : fpc_pkg::D_CLR2};
        s.last = (i != 4'h0);
      end
      fpc_pkg::OP_UNLOCK: begin
        if (i == 4'h0) begin
          s.data = {8'h00, fpc_pkg::D_PW1};
        end else if (i == 4'h1) begin
          s.data = {8'h00, fpc_pkg::D_PW2};
        end else if (i == n + fpc_pkg::PW_OFS) begin
          s.data = {8'h00, fpc_pkg::D_PWE};
          s.last = 1'b1;
        end else begin
          s.addr = {20'h00000, k};
          s.data = bm ? {8'h00, pw[{k[2:0], 3'h0} +: 8]} : pw[{k[1:0], 4'h0} +: 16];
        end
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction

  fpc_pkg::fpc_state_t state, next_state;
  fpc_pkg::fpc_op_t op, next_op;
  logic [3:0] idx, next_idx;
  logic [fpc_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [fpc_pkg::GAP_W-1:0] gap, next_gap;
  logic [7:0] code, next_code, mode, next_mode;
  logic mode_on, next_mode_on, refused, next_refused, bm, next_bm;
  logic [fpc_pkg::AW-1:0] areg, next_areg;
  logic [15:0] dreg, next_dreg, rdat, next_rdat;
  logic [63:0] pw, next_pw;
  logic [fpc_pkg::AW-1:0] next_fa;
  logic [15:0] next_fd;
  logic next_doe, next_ce, next_oe, next_we;
  logic [31:0] next_rdata;
  logic [15:0] dq_s1, dq_s2;
  fpc_pkg::fpc_step_t st;
  fpc_pkg::fpc_op_t wop;
  logic busy, go, ctl_wr, wr_ok;

  assign st = fpc_step(op, idx, bm, areg, dreg, pw, code);
  assign wop = fpc_pkg::fpc_op_t'(reg_wdata_in[3:0]);
  assign busy = (state != fpc_pkg::ST_IDLE);
  assign ctl_wr = reg_wr_in && (reg_addr_in == fpc_pkg::R_CTRL);
  assign wr_ok = reg_wr_in && !busy;
  assign go = ctl_wr && !busy && (wop != fpc_pkg::OP_NONE) && (wop <= fpc_pkg::OP_UNLOCK)
      && !((wop == fpc_pkg::OP_UNLOCK) && (gap != '0));

  always_comb begin
    next_state = state;
    next_op = op;
    next_idx = idx;
    next_cnt = cnt;
    next_code = code;
    next_mode = mode;
    next_mode_on = mode_on;
    next_gap = (gap != '0) ? gap - 1'b1 : gap;
    next_fa = fl_addr_out;
    next_fd = fl_dq_out;
    next_doe = fl_dq_oe_out;
    next_ce = fl_ce_n_out;
    next_oe = fl_oe_n_out;
    next_we = fl_we_n_out;
    next_rdat = rdat;
    case (state)
      fpc_pkg::ST_IDLE: begin
        if (go) begin
          next_state = fpc_pkg::ST_SETUP;
          next_op = wop;
          next_idx = '0;
          next_code = reg_wdata_in[fpc_pkg::CODE_LSB +: 8];
        end
      end
      fpc_pkg::ST_SETUP: begin
        next_fa = st.addr;
        next_fd = bm ? {8'h00, st.data[7:0]} : st.data;
        next_doe = !st.rd;
        next_ce = 1'b0;
        next_state = fpc_pkg::ST_STROBE;
      end
      fpc_pkg::ST_STROBE: begin
        if (st.rd) begin
          next_oe = 1'b0;
          next_cnt = fpc_pkg::CNT_W'(fpc_pkg::RD_CYC);
          next_state = fpc_pkg::ST_RWAIT;
        end else begin
          next_we = 1'b0;
          next_cnt = fpc_pkg::CNT_W'(fpc_pkg::WP_CYC);
          next_state = fpc_pkg::ST_WPULSE;
        end
      end
      fpc_pkg::ST_WPULSE: begin
        next_cnt = cnt - 1'b1;
        if (cnt == 4'h1) begin
          next_we = 1'b1;
          next_state = fpc_pkg::ST_HOLD;
        end
      end
      fpc_pkg::ST_RWAIT: begin
        next_cnt = cnt - 1'b1;
        if (cnt == 4'h1) begin
          next_oe = 1'b1;
          next_rdat = bm ? {8'h00, dq_s2[7:0]} : dq_s2;
          next_state = fpc_pkg::ST_HOLD;
        end
      end
      fpc_pkg::ST_HOLD: begin
        next_ce = 1'b1;
        next_doe = 1'b0;
        if (st.last) begin
          next_state = fpc_pkg::ST_IDLE;
          if (op == fpc_pkg::OP_ENTER) begin
            next_mode = code;
            next_mode_on = 1'b1;
          end
          if ((op == fpc_pkg::OP_EXIT) || (op == fpc_pkg::OP_EXTEXIT)) begin
            next_mode_on = 1'b0;
          end
          if (op == fpc_pkg::OP_UNLOCK) begin
            next_gap = fpc_pkg::GAP_W'(fpc_pkg::GAP_CYC);
          end
        end else begin
          next_idx = idx + 1'b1;
          next_state = fpc_pkg::ST_SETUP;
        end
      end
      default: next_state = fpc_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    next_areg = areg;
    next_dreg = dreg;
    next_pw = pw;
    next_bm = bm;
    next_rdata = 32'h00000000;
    // Refusal set wins over the status-read clear
    next_refused = (reg_wr_in && !go && (busy || ctl_wr)) ? 1'b1 :
        ((reg_rd_in && reg_addr_in == fpc_pkg::R_STAT) ? 1'b0 : refused);
    if (wr_ok) begin
      case (reg_addr_in)
        fpc_pkg::R_ADDR: next_areg = reg_wdata_in[fpc_pkg::AW-1:0];
        fpc_pkg::R_DATA: next_dreg = reg_wdata_in[15:0];
        fpc_pkg::R_PWLO: next_pw[31:0] = reg_wdata_in;
        fpc_pkg::R_PWHI: next_pw[63:32] = reg_wdata_in;
        fpc_pkg::R_CFG: next_bm = reg_wdata_in[0];
        default: next_bm = bm;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        fpc_pkg::R_ADDR: next_rdata = {8'h00, areg};
        fpc_pkg::R_DATA: next_rdata = {16'h0000, dreg};
        fpc_pkg::R_CFG: next_rdata = {31'h00000000, bm};
        fpc_pkg::R_STAT: next_rdata = {16'h0000, mode, 4'h0, gap != '0, mode_on, refused, busy};
        fpc_pkg::R_RDAT: next_rdata = {16'h0000, rdat};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    // Synchroniser: only the second stage feeds logic
    dq_s1 <= fl_dq_in;
    dq_s2 <= dq_s1;
    if (srst_in) begin
      state <= fpc_pkg::ST_IDLE;
      op <= fpc_pkg::OP_NONE;
      idx <= '0;
      cnt <= '0;
      gap <= '0;
      code <= 8'h00;
      mode <= 8'h00;
      mode_on <= 1'b0;
      refused <= 1'b0;
      bm <= 1'b0;
      areg <= '0;
      dreg <= 16'h0000;
      pw <= 64'hFFFFFFFFFFFFFFFF;
      rdat <= 16'h0000;
      reg_rdata_out <= 32'h00000000;
      fl_addr_out <= '0;
      fl_dq_out <= 16'h0000;
      fl_dq_oe_out <= 1'b0;
      fl_ce_n_out <= 1'b1;
      fl_oe_n_out <= 1'b1;
      fl_we_n_out <= 1'b1;
      fl_byte_n_out <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      idx <= next_idx;
      cnt <= next_cnt;
      gap <= next_gap;
      code <= next_code;
      mode <= next_mode;
      mode_on <= next_mode_on;
      refused <= next_refused;
      bm <= next_bm;
      areg <= next_areg;
      dreg <= next_dreg;
      pw <= next_pw;
      rdat <= next_rdat;
      reg_rdata_out <= next_rdata;
      fl_addr_out <= next_fa;
      fl_dq_out <= next_fd;
      fl_dq_oe_out <= next_doe;
      fl_ce_n_out <= next_ce;
      fl_oe_n_out <= next_oe;
      fl_we_n_out <= next_we;
      fl_byte_n_out <= !next_bm;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_wpulse;
    !fl_we_n_out [*2] ##1 fl_we_n_out;
  endsequence
  property p_wpulse;
    $fell(fl_we_n_out) |-> s_wpulse;
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("write pulse width");
  property p_first;
    $fell(fl_we_n_out) && idx == 4'h0 && (op == fpc_pkg::OP_ENTER || op == fpc_pkg::OP_EXTPROG)
        |-> fl_dq_out[7:0] == fpc_pkg::D_AA && fl_addr_out == (bm ? 24'h000AAA : 24'h000555);
  endproperty
  a_first: assert property (p_first) else $error("bad first unlock");
  property p_code;
    $fell(fl_we_n_out) && op == fpc_pkg::OP_ENTER && idx == 4'h2 |-> fl_dq_out[7:0] == code
        ##3 mode_on && mode == code;
  endproperty
  a_code: assert property (p_code) else $error("bad mode code");
  property p_exit;
    $fell(fl_we_n_out) && op == fpc_pkg::OP_EXIT && idx == 4'h1
        |-> fl_dq_out[7:0] == 8'h00 ##[1:4] !mode_on;
  endproperty
  a_exit: assert property (p_exit) else $error("exit not done");
  property p_upper;
    fl_dq_oe_out && bm |-> fl_dq_out[15:8] == 8'h00;
  endproperty
  a_upper: assert property (p_upper) else $error("upper byte driven");
  property p_read;
    !fl_oe_n_out |-> fl_we_n_out && !fl_dq_oe_out && !fl_ce_n_out && op == fpc_pkg::OP_READ;
  endproperty
  a_read: assert property (p_read) else $error("read cycle conflict");
  property p_rlen;
    $fell(fl_oe_n_out) |-> !fl_oe_n_out [*5] ##1 fl_oe_n_out;
  endproperty
  a_rlen: assert property (p_rlen) else $error("read length");
  property p_gap;
    state == fpc_pkg::ST_SETUP && op == fpc_pkg::OP_UNLOCK && idx == 4'h0 |-> gap == '0;
  endproperty
  a_gap: assert property (p_gap) else $error("unlock too soon");
  property p_pwend;
    $fell(fl_we_n_out) && op == fpc_pkg::OP_UNLOCK && idx == (bm ? 4'hA : 4'h6)
        |-> fl_dq_out[7:0] == 8'h29 && fl_addr_out == '0;
  endproperty
  a_pwend: assert property (p_pwend) else $error("unlock close");
endmodule // fpc_host
`default_nettype wire

// [design/fpc_pkg.sv]
// Shared constants and types for the flash protection command host
`default_nettype none
package fpc_pkg;
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int GAP_NS = 6000;
  localparam int WP_NS = 80;
  localparam int ACC_NS = 120;
  localparam int SYNC_CYC = 2;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (WP_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC = (ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
  localparam int GAP_W = 8;
  localparam int CNT_W = 4;
  // Flash bus
  localparam int AW = 24;
  localparam int DW = 16;
  localparam logic [AW-1:0] UA1_B = 24'h000AAA;
  localparam logic [AW-1:0] UA2_B = 24'h000555;
  localparam logic [AW-1:0] UA1_W = 24'h000555;
  localparam logic [AW-1:0] UA2_W = 24'h0002AA;
  localparam logic [AW-1:0] XIT_A = 24'h000555;
  localparam logic [7:0] D_AA = 8'hAA;
  localparam logic [7:0] D_55 = 8'h55;
  localparam logic [7:0] D_PRG = 8'hA0;
  localparam logic [7:0] D_EXIT = 8'h90;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [7:0] D_CLR1 = 8'h80;
  localparam logic [7:0] D_CLR2 = 8'h30;
  localparam logic [7:0] D_PW1 = 8'h25;
  localparam logic [7:0] D_PW2 = 8'h03;
  localparam logic [7:0] D_PWE = 8'h29;
  localparam logic [3:0] PW_N_B = 4'h8;
  localparam logic [3:0] PW_N_W = 4'h4;
  localparam logic [3:0] PW_OFS = 4'h2;
  // Registers on the software port
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_ADDR = 8'h04;
  localparam logic [7:0] R_DATA = 8'h08;
  localparam logic [7:0] R_PWLO = 8'h0C;
  localparam logic [7:0] R_PWHI = 8'h10;
  localparam logic [7:0] R_CFG = 8'h14;
  localparam logic [7:0] R_STAT = 8'h18;
  localparam logic [7:0] R_RDAT = 8'h1C;
  localparam int CODE_LSB = 8;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ENTER = 4'h1, OP_EXIT = 4'h2, OP_PROG = 4'h3,
    OP_READ = 4'h4, OP_CLRALL = 4'h5, OP_EXTPROG = 4'h6, OP_EXTEXIT = 4'h7,
    OP_UNLOCK = 4'h8
  } fpc_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_SETUP = 3'h1, ST_STROBE = 3'h2,
    ST_WPULSE = 3'h3, ST_RWAIT = 3'h4, ST_HOLD = 3'h5
  } fpc_state_t;
  typedef struct packed {
    logic rd;
    logic last;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } fpc_step_t;
endpackage
`default_nettype wire

// [tb/fpc_flash_model.sv]
// Behavioural flash device answering the protection command sets
`default_nettype none
module fpc_flash_model (
  // Host pins
  input wire logic [23:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic byte_n_in,
  // Pins back and observed state
  output logic [15:0] dq_out,
  output logic [7:0] mode_out,
  output logic [3:0] unlock_cnt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] vbit = '1;
  logic [127:0] nvbit = '1;
  logic lockb = 1'b1;
  logic clr = 1'b0;
  logic [15:0] ext [0:127];
  logic [63:0] pw = '1;
  logic [1:0] seq = 2'h0;
  logic prg = 1'b0;
  logic xit = 1'b0;
  logic bad = 1'b0;
  logic [3:0] pwn = 4'h0;
  logic [15:0] rdat;
  logic [15:0] last = 16'h0;
  logic [7:0] d;
  logic [15:0] a;
  realtime t_end = -1.0e6;
  wire bm = !byte_n_in;
  wire [3:0] n = bm ? 4'h8 : 4'h4;
  wire [15:0] u1 = bm ? 16'h0AAA : 16'h0555;
  wire [15:0] u2 = bm ? 16'h0555 : 16'h02AA;
  function automatic logic [6:0] blk(input logic [23:0] x);
    return bm ? x[23:17] : x[22:16];
  endfunction
  function automatic logic [15:0] portion(input logic [23:0] x);
    return bm ? {8'h0, pw[x[2:0]*8 +: 8]} : pw[x[1:0]*16 +: 16];
  endfunction
  initial begin
    mode_out = 8'h00;
    unlock_cnt_out = 4'h0;
  end
  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      d = dq_in[7:0];
      a = addr_in[15:0];
      if (prg) begin
        prg = 1'b0;
        // Block 0 stays untouched while the E0 set is active
        if (mode_out == 8'hE0 && blk(addr_in) != 7'h0) vbit[blk(addr_in)] = d[0];
        if (mode_out == 8'h88) ext[addr_in[6:0]] = dq_in;
        if (mode_out == 8'hC0 && lockb) nvbit[blk(addr_in)] = 1'b0;
        if (mode_out == 8'h50) lockb = 1'b0;
        if (mode_out == 8'h60 && bm) pw[addr_in[2:0]*8 +: 8] = d;
        if (mode_out == 8'h60 && !bm) pw[addr_in[1:0]*16 +: 16] = dq_in;
      end else if (pwn >= 4'h2 && pwn < 4'h2 + n) begin
        if ((bm ? {8'h0, d} : dq_in) !== portion(addr_in)) bad = 1'b1;
        pwn++;
      end else if (pwn == 4'h2 + n) begin
        if (d == 8'h29 && !bad) unlock_cnt_out++;
        t_end = $realtime;
        pwn = 4'h0;
      end else if (pwn == 4'h1) begin
        pwn = (d == 8'h03) ? 4'h2 : 4'h0;
      end else if (mode_out == 8'h60 && d == 8'h25 && $realtime - t_end >= 6000.0) begin
        pwn = 4'h1;
        bad = 1'b0;
      end else if (mode_out == 8'hC0 && d == 8'h80) begin
        clr = 1'b1;
      end else if (clr && d == 8'h30) begin
        clr = 1'b0;
        // Pre-program all bits so none is over-erased; a set lock bit vetoes both
        if (lockb) begin
          nvbit = '0;
          nvbit = '1;
        end
      end else if (d == 8'h90 && mode_out != 8'h00) begin
        xit = 1'b1;
        seq = 2'h0;
      end else if (xit && d == 8'h00) begin
        mode_out = 8'h00;
        xit = 1'b0;
      end else if (seq == 2'h0 && a == u1 && d == 8'hAA) begin
        seq = 2'h1;
      end else if (seq == 2'h1 && a == u2 && d == 8'h55) begin
        seq = 2'h2;
      end else if (seq == 2'h2 && a == u1) begin
        seq = 2'h0;
        if (mode_out == 8'h00 && d inside {8'h50, 8'hE0, 8'h88, 8'h60, 8'hC0}) mode_out = d;
        else if (d == 8'hA0) prg = 1'b1;
      end else if (mode_out != 8'h00 && d == 8'hA0) begin
        prg = 1'b1;
      end else begin
        seq = 2'h0;
      end
    end
  end
  always_comb begin
    case (mode_out)
      8'hE0: rdat = {15'h0, vbit[blk(addr_in)] & nvbit[blk(addr_in)]};
      8'hC0: rdat = {15'h0, nvbit[blk(addr_in)]};
      8'h50: rdat = {15'h0, lockb};
      8'h88: rdat = ext[addr_in[6:0]];
      8'h60: rdat = portion(addr_in);
      default: rdat = addr_in[15:0] ^ 16'h5A5A;
    endcase
  end
  always @(posedge oe_n_in) last = rdat;
  // Released bus shows the inverse so stale data never matches by luck
  assign dq_out = (!ce_n_in && !oe_n_in) ? rdat : ~last;
endmodule // fpc_flash_model
`default_nettype wire

// [tb/fpc_host_tb_top.sv]
// Self-checking testbench for the flash protection command host
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module fpc_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] e; logic [31:0] m;} fpc_exp_t;
  fpc_exp_t q[$];
  fpc_exp_t x;
  int err_count = 0;
  int total_checks = 0;
  int seed;
  int p;
  logic [7:0] r;
  logic [7:0] codes [3] = '{8'h50, 8'hE0, 8'h88};
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [23:0] fl_addr_out;
  logic [15:0] fl_dq_in;
  logic [15:0] fl_dq_out;
  logic fl_dq_oe_out, fl_ce_n_out, fl_oe_n_out, fl_we_n_out, fl_byte_n_out;
  logic [7:0] mode;
  logic [3:0] ucnt;
  always #20 clk_in = ~clk_in;
  fpc_host dut_u (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .fl_addr_out(fl_addr_out), .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe_out(fl_dq_oe_out), .fl_ce_n_out(fl_ce_n_out),
    .fl_oe_n_out(fl_oe_n_out), .fl_we_n_out(fl_we_n_out), .fl_byte_n_out(fl_byte_n_out));
  fpc_flash_model dev_u (.addr_in(fl_addr_out), .dq_in(fl_dq_out), .ce_n_in(fl_ce_n_out),
    .oe_n_in(fl_oe_n_out), .we_n_in(fl_we_n_out), .byte_n_in(fl_byte_n_out),
    .dq_out(fl_dq_in), .mode_out(mode), .unlock_cnt_out(ucnt));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
  endtask
  // Polls busy; a bounded loop so a stuck sequencer is counted below, not left to the watchdog
  task automatic op(input logic [3:0] o, input logic [7:0] c);
    logic [31:0] s;
    wr(fpc_pkg::R_CTRL, {16'h0, c, 4'h0, o});
    s = 32'h1;
    for (int i = 0; i < 100 && s[0]; i++) begin
      rd(fpc_pkg::R_STAT, 32'h0, 32'h0);
      #1 s = reg_rdata_out;
    end
    // A sequencer that never drops busy counts as a failure
    if (s[0]) err_count++;
  endtask
  function automatic logic [23:0] baddr(input bit bm, input logic [6:0] b);
    return bm ? {b, 17'($urandom)} : {1'b0, b, 16'($urandom)};
  endfunction
  task automatic prot(input bit bm);
    logic [6:0] b;
    b = 7'($urandom_range(127, 1));
    for (int k = 0; k < 2; k++) begin
      wr(fpc_pkg::R_ADDR, 32'(baddr(bm, b)));
      wr(fpc_pkg::R_DATA, 32'(k));
      op(fpc_pkg::OP_PROG, 8'h00);
      wr(fpc_pkg::R_ADDR, 32'(baddr(bm, b)));
      op(fpc_pkg::OP_READ, 8'h00);
      rd(fpc_pkg::R_RDAT, 32'(k), 32'hFF);
    end
  endtask
  task automatic extblk();
    logic [15:0] d;
    d = 16'($urandom);
    wr(fpc_pkg::R_ADDR, {25'h0, 7'($urandom)});
    wr(fpc_pkg::R_DATA, 32'(d));
    op(fpc_pkg::OP_EXTPROG, 8'h00);
    op(fpc_pkg::OP_READ, 8'h00);
    rd(fpc_pkg::R_RDAT, 32'(d), 32'hFFFF);
  endtask
  // Second pass sets the lock bit first, so its clear-all must leave the bit set
  task automatic nvclr();
    logic [6:0] b;
    b = 7'($urandom_range(127, 1));
    for (int k = 0; k < 2; k++) begin
      wr(fpc_pkg::R_ADDR, 32'(baddr(1'b0, b)));
      wr(fpc_pkg::R_DATA, 32'h0);
      op(fpc_pkg::OP_ENTER, 8'hC0);
      op(fpc_pkg::OP_PROG, 8'h00);
      op(fpc_pkg::OP_EXIT, 8'h00);
      op(fpc_pkg::OP_ENTER, 8'hE0);
      op(fpc_pkg::OP_READ, 8'h00);
      rd(fpc_pkg::R_RDAT, 32'h0, 32'hFF);
      op(fpc_pkg::OP_EXIT, 8'h00);
      if (k == 1) begin
        op(fpc_pkg::OP_ENTER, 8'h50);
        op(fpc_pkg::OP_PROG, 8'h00);
        op(fpc_pkg::OP_READ, 8'h00);
        rd(fpc_pkg::R_RDAT, 32'h0, 32'hFF);
        op(fpc_pkg::OP_EXIT, 8'h00);
      end
      op(fpc_pkg::OP_ENTER, 8'hC0);
      op(fpc_pkg::OP_CLRALL, 8'h00);
      op(fpc_pkg::OP_READ, 8'h00);
      rd(fpc_pkg::R_RDAT, 32'(1 - k), 32'hFF);
      op(fpc_pkg::OP_EXIT, 8'h00);
    end
  endtask
  task automatic complete_run();
    // Expectations never matched by a read are failures too
    if (q.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (rd_d && q.size() > 0) begin
      x = q.pop_front();
      if (x.m != 32'h0) `CHK(reg_rdata_out & x.m, x.e & x.m)
    end
    rd_d <= reg_rd_in;
  end
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
  initial begin
    seed = $urandom(76718);
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(fpc_pkg::R_STAT, 32'h0, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    for (int bm = 0; bm < 2; bm++) begin
      wr(fpc_pkg::R_CFG, 32'(bm));
      foreach (codes[k]) begin
        op(fpc_pkg::OP_ENTER, codes[k]);
        `CHK(mode, codes[k])
        rd(fpc_pkg::R_STAT, {16'h0, codes[k], 8'h04}, 32'hFF07);
        if (codes[k] == 8'hE0) prot(bm[0]);
        if (codes[k] == 8'h88 && bm == 0) extblk();
        op(codes[k] == 8'h88 ? fpc_pkg::OP_EXTEXIT : fpc_pkg::OP_EXIT, 8'h00);
        `CHK(mode, 8'h00)
      end
    end
    wr(fpc_pkg::R_CFG, 32'h0);
    nvclr();
    op(fpc_pkg::OP_ENTER, 8'h60);
    wr(fpc_pkg::R_ADDR, 32'h2);
    op(fpc_pkg::OP_READ, 8'h00);
    rd(fpc_pkg::R_RDAT, 32'hFFFF, 32'hFFFF);
    op(fpc_pkg::OP_UNLOCK, 8'h00);
    `CHK(ucnt, 4'h1)
    // Second unlock inside the spacing window must be turned away
    wr(fpc_pkg::R_CTRL, 32'(fpc_pkg::OP_UNLOCK));
    rd(fpc_pkg::R_STAT, 32'hA, 32'hB);
    rd(fpc_pkg::R_STAT, 32'h8, 32'hA);
    `CHK(ucnt, 4'h1)
    repeat (160) @(posedge clk_in);
    wr(fpc_pkg::R_CFG, 32'h1);
    wr(fpc_pkg::R_PWHI, $urandom & 32'h7FFFFFFF);
    op(fpc_pkg::OP_UNLOCK, 8'h00);
    `CHK(ucnt, 4'h1)
    repeat (160) @(posedge clk_in);
    wr(fpc_pkg::R_PWHI, 32'hFFFFFFFF);
    op(fpc_pkg::OP_UNLOCK, 8'h00);
    `CHK(ucnt, 4'h2)
    p = $urandom_range(7, 0);
    r = 8'($urandom);
    wr(fpc_pkg::R_ADDR, 32'(p));
    wr(fpc_pkg::R_DATA, {24'h0, r});
    op(fpc_pkg::OP_PROG, 8'h00);
    for (int j = 0; j < 8; j++) begin
      wr(fpc_pkg::R_ADDR, 32'(j));
      op(fpc_pkg::OP_READ, 8'h00);
      rd(fpc_pkg::R_RDAT, (j == p) ? {24'h0, r} : 32'hFF, 32'hFF);
    end
    wr(fpc_pkg::R_CTRL, 32'(fpc_pkg::OP_READ));
    wr(fpc_pkg::R_CTRL, 32'(fpc_pkg::OP_EXIT));
    rd(fpc_pkg::R_STAT, 32'h3, 32'h3);
    repeat (12) @(posedge clk_in);
    `CHK(mode, 8'h60)
    op(fpc_pkg::OP_EXIT, 8'h00);
    `CHK(mode, 8'h00)
    repeat (3) @(posedge clk_in);
    complete_run();
  end
endmodule // fpc_host_tb_top
`default_nettype wire
